// file: acfp_path.sv
// Fixed-point angle, current scaling and gain path with its register file.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module acfp_path #(
    parameter int ENC_BITS = 16,
    parameter int INC_BITS = 16
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Register port.
    input wire logic [acfp_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // Converter samples and position sensors.
    input wire acfp_pkg::acfp_adc_raw_t i_adc,
    input wire logic i_adc_valid,
    input wire logic [15:0] i_hall_angle,
    input wire logic [ENC_BITS-1:0] i_aenc_angle,
    input wire logic [INC_BITS-1:0] i_inc_count,
    input wire logic signed [31:0] i_loop_error,
    // Results.
    output acfp_pkg::acfp_angle_t o_angles,
    output acfp_pkg::acfp_current_t o_currents,
    output logic [acfp_pkg::SCALED_CH-1:0] o_neg_to_gnd,
    output logic [15:0] o_aux_target,
    output logic signed [31:0] o_gain_product
);

    if (ENC_BITS < 1 || ENC_BITS > acfp_pkg::ANGLE_W) begin : g_enc_chk
        $error("ENC_BITS must lie between 1 and 16");
    end
    if (INC_BITS < 1 || INC_BITS > acfp_pkg::ANGLE_W) begin : g_inc_chk
        $error("INC_BITS must lie between 1 and 16");
    end
    // Sample carrier and calibration span must agree with the channel counts used below.
    if ($bits(acfp_pkg::acfp_adc_raw_t) != 16 * acfp_pkg::RAW_CH) begin : g_raw_chk
        $error("Raw sample carrier does not hold RAW_CH channels");
    end
    if (int'(acfp_pkg::REG_CAL_LAST - acfp_pkg::REG_CAL_FIRST)
            != 4 * (acfp_pkg::SCALED_CH - 1)) begin : g_cal_chk
        $error("Calibration block does not span SCALED_CH registers");
    end

    // Symmetric clip to sixteen bits, so a later negation cannot overflow.
    function automatic logic signed [15:0] clip16(input logic signed [49:0] v);
        logic signed [49:0] lim;
        lim = 50'(acfp_pkg::S16_MAX);
        if (v > lim) begin
            clip16 = acfp_pkg::S16_MAX;
        end else if (v < -lim) begin
            clip16 = -acfp_pkg::S16_MAX;
        end else begin
            clip16 = v[15:0];
        end
    endfunction

    // Symmetric clip to thirty-two bits.
    function automatic logic signed [31:0] clip32(input logic signed [63:0] v);
        logic signed [63:0] lim;
        lim = 64'(acfp_pkg::S32_MAX);
        if (v > lim) begin
            clip32 = acfp_pkg::S32_MAX;
        end else if (v < -lim) begin
            clip32 = -acfp_pkg::S32_MAX;
        end else begin
            clip32 = v[31:0];
        end
    endfunction

    // Index of a calibration register, or SCALED_CH when the address is outside that block.
    function automatic int cal_index(input logic [acfp_pkg::ADDR_W-1:0] a);
        if (a >= acfp_pkg::REG_CAL_FIRST && a <= acfp_pkg::REG_CAL_LAST && a[1:0] == 2'h0) begin
            cal_index = int'((a - acfp_pkg::REG_CAL_FIRST) >> 2);
        end else begin
            cal_index = acfp_pkg::SCALED_CH;
        end
    endfunction

    // Mechanical angle from an electrical one; the sub-step remainder is dropped.
    function automatic logic [15:0] elec_to_mech(input logic [15:0] e, input logic [7:0] pp);
        elec_to_mech = 16'(e / pp);
    endfunction

    // Control registers.
    logic [7:0] pole_pairs_r;
    logic [15:0] angle_shift_r;
    logic shift_sub_r;
    logic [acfp_pkg::SCALED_CH-1:0] single_ended_r;
    logic target_sel_r;
    acfp_pkg::acfp_pos_src_t pos_src_r;
    logic [15:0] cal_offset_r [acfp_pkg::SCALED_CH];
    logic signed [15:0] cal_scale_r [acfp_pkg::SCALED_CH];
    logic signed [15:0] gain_r;
    logic gain_fmt_r;
    logic [2:0] raw_sel_r;
    logic [INC_BITS-1:0] inc_base_r;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pole_pairs_r <= acfp_pkg::POLE_PAIRS_RST;
            angle_shift_r <= acfp_pkg::ANGLE_SHIFT_RST;
            shift_sub_r <= 1'b0;
            single_ended_r <= '0;
            target_sel_r <= 1'b0;
            pos_src_r <= acfp_pkg::POS_HALL;
            gain_r <= '0;
            gain_fmt_r <= 1'b0;
            raw_sel_r <= '0;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                acfp_pkg::REG_POLE_PAIRS: begin
                    pole_pairs_r <= i_reg_wdata[7:0];
                end
                acfp_pkg::REG_ANGLE_SHIFT: begin
                    angle_shift_r <= i_reg_wdata[15:0];
                    shift_sub_r <= i_reg_wdata[acfp_pkg::SHIFT_DIR_BIT];
                end
                acfp_pkg::REG_INPUT_CFG: begin
                    single_ended_r <= i_reg_wdata[acfp_pkg::CFG_SE_LSB +: acfp_pkg::SCALED_CH];
                    target_sel_r <= i_reg_wdata[acfp_pkg::CFG_TARGET_BIT];
                    pos_src_r <= acfp_pkg::acfp_pos_src_t'(i_reg_wdata[acfp_pkg::CFG_POS_SRC_LSB +: 2]);
                end
                acfp_pkg::REG_GAIN: begin
                    gain_r <= i_reg_wdata[15:0];
                    gain_fmt_r <= i_reg_wdata[acfp_pkg::GAIN_FMT_BIT];
                end
                acfp_pkg::REG_RAW_SEL: begin
                    raw_sel_r <= i_reg_wdata[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Zeroing the incremental count keeps the present count as the new origin.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            inc_base_r <= '0;
        end else if (i_reg_wr && i_reg_addr == acfp_pkg::REG_ENC_ZERO) begin
            inc_base_r <= i_inc_count;
        end
    end

    // Offset and scale pairs for the two current and three position channels.
    for (genvar k = 0; k < acfp_pkg::SCALED_CH; k++) begin : g_cal
        always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
                cal_offset_r[k] <= acfp_pkg::CAL_OFFSET_RST;
                cal_scale_r[k] <= acfp_pkg::CAL_SCALE_RST;
            end else if (i_reg_wr && cal_index(i_reg_addr) == k) begin
                cal_offset_r[k] <= i_reg_wdata[15:0];
                cal_scale_r[k] <= i_reg_wdata[acfp_pkg::CAL_SCALE_LSB +: 16];
            end
        end
    end

    // Sampling: one set of eight raw values is held per converter strobe.
    acfp_pkg::acfp_adc_raw_t raw_r;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            raw_r <= '0;
        end else if (i_adc_valid) begin
            raw_r <= i_adc;
        end
    end

    // Scaled channels in order: current first, current second, position first, index, third.
    logic [15:0] scale_in [acfp_pkg::SCALED_CH];
    logic signed [15:0] scaled_r [acfp_pkg::SCALED_CH];
    assign scale_in[0] = raw_r.cur_first;
    assign scale_in[1] = raw_r.cur_second;
    assign scale_in[2] = raw_r.pos_first;
    assign scale_in[3] = raw_r.pos_index;
    assign scale_in[4] = raw_r.pos_third;

    for (genvar k = 0; k < acfp_pkg::SCALED_CH; k++) begin : g_scale
        logic signed [16:0] diff;
        logic signed [33:0] prod;
        assign diff = $signed({1'b0, scale_in[k]}) - $signed({1'b0, cal_offset_r[k]});
        assign prod = diff * cal_scale_r[k];
        always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
                scaled_r[k] <= '0;
            end else begin
                scaled_r[k] <= clip16(50'(prod >>> acfp_pkg::SCALE_FRAC));
            end
        end
    end

    // The third phase is never sampled; it follows from the other two.
    logic signed [17:0] cur_sum;
    assign cur_sum = 18'(scaled_r[0]) + 18'(scaled_r[1]);
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_currents <= '0;
        end else begin
            o_currents.first <= scaled_r[0];
            o_currents.second <= scaled_r[1];
            o_currents.derived <= clip16(50'(-cur_sum));
        end
    end

    // Single-ended channels ground their negative input inside the device.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_neg_to_gnd <= '0;
        end else begin
            o_neg_to_gnd <= single_ended_r;
        end
    end

    // The target value is forced to zero while the auxiliary source is not selected.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_aux_target <= '0;
        end else begin
            o_aux_target <= target_sel_r ? raw_r.aux_first : 16'h0000;
        end
    end

    // Position sources mapped onto sixteen bits by left alignment.
    logic [15:0] aenc_mech;
    logic [15:0] inc_mech;
    logic [INC_BITS-1:0] inc_rel;
    assign aenc_mech = 16'({i_aenc_angle, 16'h0000} >> ENC_BITS);
    assign inc_rel = i_inc_count - inc_base_r;
    assign inc_mech = 16'({inc_rel, 16'h0000} >> INC_BITS);

    // A pole pair count of zero would stall the divider, so it acts as one.
    logic [7:0] pp_eff;
    logic [23:0] mech_times_pp;
    logic [15:0] mech_src;
    logic [15:0] elec_raw;
    logic [15:0] mech_raw;
    logic [15:0] elec_shifted;
    assign pp_eff = (pole_pairs_r == 8'h00) ? 8'h01 : pole_pairs_r;
    assign mech_src = (pos_src_r == acfp_pkg::POS_INCR) ? inc_mech : aenc_mech;
    assign mech_times_pp = mech_src * pp_eff;

    always_comb begin
        case (pos_src_r)
            acfp_pkg::POS_HALL: begin
                elec_raw = i_hall_angle;
                mech_raw = elec_to_mech(i_hall_angle, pp_eff);
            end
            acfp_pkg::POS_ANALOG, acfp_pkg::POS_INCR: begin
                elec_raw = mech_times_pp[15:0];
                mech_raw = mech_src;
            end
            default: begin
                elec_raw = i_hall_angle;
                mech_raw = elec_to_mech(i_hall_angle, pp_eff);
            end
        endcase
    end

    // Sixteen-bit add or subtract wraps naturally through a full turn.
    assign elec_shifted = shift_sub_r ? elec_raw - angle_shift_r
                                      : elec_raw + angle_shift_r;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_angles <= '0;
        end else begin
            o_angles.electrical <= elec_shifted;
            o_angles.mechanical <= mech_raw;
        end
    end

    // Gains are positive in use but enter the product signed, since errors are signed.
    logic signed [47:0] gain_prod;
    logic signed [47:0] gain_aligned;
    assign gain_prod = gain_r * i_loop_error;
    assign gain_aligned = gain_fmt_r ? (gain_prod >>> acfp_pkg::FRAC_4_12)
                                     : (gain_prod >>> acfp_pkg::FRAC_8_8);
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_gain_product <= '0;
        end else begin
            o_gain_product <= clip32(64'(gain_aligned));
        end
    end

    // Raw view of any of the eight channels.
    logic [15:0] raw_view;
    always_comb begin
        case (raw_sel_r)
            3'h0: raw_view = raw_r.cur_first;
            3'h1: raw_view = raw_r.cur_second;
            3'h2: raw_view = raw_r.supply;
            3'h3: raw_view = raw_r.aux_first;
            3'h4: raw_view = raw_r.aux_second;
            3'h5: raw_view = raw_r.pos_first;
            3'h6: raw_view = raw_r.pos_index;
            default: raw_view = raw_r.pos_third;
        endcase
    end

    // Read mux; unmapped addresses read as zero.
    logic [31:0] rd_nxt;
    int ci;
    always_comb begin
        rd_nxt = '0;
        ci = cal_index(i_reg_addr);
        if (ci < acfp_pkg::SCALED_CH) begin
            rd_nxt = {cal_scale_r[ci], cal_offset_r[ci]};
        end else begin
            case (i_reg_addr)
                acfp_pkg::REG_POLE_PAIRS: rd_nxt = {24'h000000, pole_pairs_r};
                acfp_pkg::REG_ANGLE_SHIFT: rd_nxt = {15'h0000, shift_sub_r, angle_shift_r};
                acfp_pkg::REG_INPUT_CFG: begin
                    rd_nxt[acfp_pkg::CFG_SE_LSB +: acfp_pkg::SCALED_CH] = single_ended_r;
                    rd_nxt[acfp_pkg::CFG_TARGET_BIT] = target_sel_r;
                    rd_nxt[acfp_pkg::CFG_POS_SRC_LSB +: 2] = pos_src_r;
                end
                acfp_pkg::REG_ENC_ZERO: rd_nxt = 32'(inc_rel);
                acfp_pkg::REG_GAIN: rd_nxt = {15'h0000, gain_fmt_r, gain_r};
                acfp_pkg::REG_RAW_SEL: rd_nxt = {29'h00000000, raw_sel_r};
                acfp_pkg::REG_CUR_MEAS: rd_nxt = {scaled_r[1], scaled_r[0]};
                acfp_pkg::REG_CUR_DERIVED: rd_nxt = {16'h0000, o_currents.derived};
                acfp_pkg::REG_POS_FIRST_INDEX: rd_nxt = {scaled_r[3], scaled_r[2]};
                acfp_pkg::REG_POS_THIRD: rd_nxt = {16'h0000, scaled_r[4]};
                acfp_pkg::REG_SUPPLY: rd_nxt = {16'h0000, raw_r.supply};
                acfp_pkg::REG_AUX: rd_nxt = {raw_r.aux_second, raw_r.aux_first};
                acfp_pkg::REG_ANGLES: rd_nxt = {o_angles.mechanical, o_angles.electrical};
                acfp_pkg::REG_RAW_VIEW: rd_nxt = {16'h0000, raw_view};
                acfp_pkg::REG_GAIN_OUT: rd_nxt = o_gain_product;
                default: rd_nxt = '0;
            endcase
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_reg_rdata <= '0;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rd_nxt;
        end else begin
            o_reg_rdata <= '0;
        end
    end

endmodule
`default_nettype wire

// file: acfp_pkg.sv
// Shared constants and types for the angle and current fixed-point path.
package acfp_pkg;

    // Register map, byte addresses on the plain register port.
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_POLE_PAIRS = 8'h00;
    localparam logic [7:0] REG_ANGLE_SHIFT = 8'h04;
    localparam logic [7:0] REG_INPUT_CFG = 8'h08;
    localparam logic [7:0] REG_ENC_ZERO = 8'h0C;
    localparam logic [7:0] REG_CAL_FIRST = 8'h10;
    localparam logic [7:0] REG_CAL_LAST = 8'h20;
    localparam logic [7:0] REG_GAIN = 8'h24;
    localparam logic [7:0] REG_RAW_SEL = 8'h28;
    localparam logic [7:0] REG_CUR_MEAS = 8'h2C;
    localparam logic [7:0] REG_CUR_DERIVED = 8'h30;
    localparam logic [7:0] REG_POS_FIRST_INDEX = 8'h34;
    localparam logic [7:0] REG_POS_THIRD = 8'h38;
    localparam logic [7:0] REG_SUPPLY = 8'h3C;
    localparam logic [7:0] REG_AUX = 8'h40;
    localparam logic [7:0] REG_ANGLES = 8'h44;
    localparam logic [7:0] REG_RAW_VIEW = 8'h48;
    localparam logic [7:0] REG_GAIN_OUT = 8'h4C;

    // Field positions.
    localparam int SHIFT_DIR_BIT = 16;
    localparam int CFG_SE_LSB = 0;
    localparam int CFG_TARGET_BIT = 8;
    localparam int CFG_POS_SRC_LSB = 12;
    localparam int GAIN_FMT_BIT = 16;
    localparam int CAL_SCALE_LSB = 16;
    localparam int HI_LSB = 16;

    // Reset values.
    localparam logic [7:0] POLE_PAIRS_RST = 8'h01;
    localparam logic [15:0] CAL_OFFSET_RST = 16'h0000;
    localparam logic [15:0] CAL_SCALE_RST = 16'h0100;
    localparam logic [15:0] ANGLE_SHIFT_RST = 16'h0000;

    // Number formats.
    localparam int SCALE_FRAC = 8;
    localparam int FRAC_8_8 = 8;
    localparam int FRAC_4_12 = 12;
    localparam logic signed [15:0] S16_MAX = 16'sh7FFF;
    localparam logic [15:0] U16_MAX = 16'hFFFF;
    localparam logic signed [31:0] S32_MAX = 32'sh7FFFFFFF;
    localparam int ANGLE_W = 16;
    localparam int SCALED_CH = 5;
    localparam int RAW_CH = 8;

    // Source of the rotor position.
    typedef enum logic [1:0] {
        POS_HALL,
        POS_ANALOG,
        POS_INCR
    } acfp_pos_src_t;

    // One set of raw samples from the eight converter channels.
    typedef struct packed {
        logic [15:0] cur_first;
        logic [15:0] cur_second;
        logic [15:0] supply;
        logic [15:0] aux_first;
        logic [15:0] aux_second;
        logic [15:0] pos_first;
        logic [15:0] pos_index;
        logic [15:0] pos_third;
    } acfp_adc_raw_t;

    typedef struct packed {
        logic [15:0] electrical;
        logic [15:0] mechanical;
    } acfp_angle_t;

    typedef struct packed {
        logic signed [15:0] first;
        logic signed [15:0] second;
        logic signed [15:0] derived;
    } acfp_current_t;

endpackage

// file: acfp_path_checker.sv
// Port-level assertions for the fixed-point angle and current path.
`timescale 1ns/1ps
`default_nettype none
module acfp_path_checker (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Register port.
    input wire logic [acfp_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [31:0] o_reg_rdata,
    // Samples and results.
    input wire acfp_pkg::acfp_adc_raw_t i_adc,
    input wire logic i_adc_valid,
    input wire acfp_pkg::acfp_angle_t o_angles,
    input wire acfp_pkg::acfp_current_t o_currents,
    input wire logic [acfp_pkg::SCALED_CH-1:0] o_neg_to_gnd,
    input wire logic [15:0] o_aux_target,
    input wire logic signed [31:0] o_gain_product
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // The derived current is registered in the same cycle as the measured pair; it is still only judged once traffic is quiet.
    logic [2:0] quiet_r;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_adc_valid || i_reg_wr) begin
            quiet_r <= 3'h0;
        end else if (quiet_r != 3'h7) begin
            quiet_r <= quiet_r + 3'h1;
        end
    end
    function automatic logic [15:0] neg_sum(input logic [15:0] a, input logic [15:0] b);
        logic signed [17:0] s;
        s = -($signed({{2{a[15]}}, a}) + $signed({{2{b[15]}}, b}));
        if (s > 18'sh07FFF) return 16'h7FFF;
        if (s < -18'sh07FFF) return 16'h8001;
        return s[15:0];
    endfunction
    property p_rd_idle;
        !$past(i_reg_rd) |-> o_reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_rd_void;
        i_reg_rd && i_reg_addr == 8'hFC |=> o_reg_rdata == 32'h0;
    endproperty
    a_rd_void: assert property (p_rd_void) else $error("unmapped read not zero");
    property p_rd_angles;
        i_reg_rd && i_reg_addr == acfp_pkg::REG_ANGLES
            |=> o_reg_rdata == {$past(o_angles.mechanical), $past(o_angles.electrical)};
    endproperty
    a_rd_angles: assert property (p_rd_angles) else $error("angle read mismatch");
    property p_cur_sym;
        o_currents.first != 16'h8000 && o_currents.second != 16'h8000
            && o_currents.derived != 16'h8000;
    endproperty
    a_cur_sym: assert property (p_cur_sym) else $error("current not clipped");
    property p_gain_sym;
        o_gain_product != 32'sh80000000;
    endproperty
    a_gain_sym: assert property (p_gain_sym) else $error("product not clipped");
    property p_derived;
        quiet_r == 3'h7 |-> o_currents.derived == neg_sum(o_currents.first, o_currents.second);
    endproperty
    a_derived: assert property (p_derived) else $error("derived current wrong");
    property p_aux_val;
        $past(i_adc_valid, 2) && o_aux_target != 16'h0 |-> o_aux_target == $past(i_adc.aux_first, 2);
    endproperty
    a_aux_val: assert property (p_aux_val) else $error("aux target value wrong");
    property p_aux_hold;
        $changed(o_aux_target) |-> $past(i_adc_valid, 2) || $past(i_reg_wr) || $past(i_reg_wr, 2);
    endproperty
    a_aux_hold: assert property (p_aux_hold) else $error("aux target moved alone");
    property p_gnd_hold;
        $changed(o_neg_to_gnd) |-> $past(i_reg_wr) || $past(i_reg_wr, 2);
    endproperty
    a_gnd_hold: assert property (p_gnd_hold) else $error("ground tie moved alone");
    c_rd_angles: cover property (i_reg_rd && i_reg_addr == acfp_pkg::REG_ANGLES);
    c_clip: cover property (o_currents.derived == 16'h8001);
    c_aux: cover property (o_aux_target != 16'h0);
endmodule
bind acfp_path acfp_path_checker i_acfp_path_checker (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_adc(i_adc), .i_adc_valid(i_adc_valid),
    .o_angles(o_angles), .o_currents(o_currents), .o_neg_to_gnd(o_neg_to_gnd),
    .o_aux_target(o_aux_target), .o_gain_product(o_gain_product)
);
`default_nettype wire

// file: acfp_sensor_model.sv
// Behavioural model of the sense amplifiers and analog position sensors.
`timescale 1ns/1ps
`default_nettype none
module acfp_sensor_model (
    // Clock.
    input wire logic i_clk,
    // Sample request.
    input wire logic i_go,
    input wire acfp_pkg::acfp_adc_raw_t i_smp,
    // Converter side.
    output acfp_pkg::acfp_adc_raw_t o_adc,
    output logic o_valid
);
    initial begin
        o_adc = '0;
        o_valid = 1'b0;
    end
    // Between strobes the word is inverted, so latching at the wrong edge cannot match by luck.
    always @(posedge i_clk) begin
        o_valid <= i_go;
        o_adc <= i_go ? i_smp : ~o_adc;
    end
endmodule
`default_nettype wire

// file: acfp_path_tb.sv
// Self-checking bench for the fixed-point angle and current path.
`timescale 1ns/1ps
`default_nettype none
module acfp_path_tb;
    logic i_clk;
    logic i_sys_rst;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    acfp_pkg::acfp_adc_raw_t adc;
    acfp_pkg::acfp_adc_raw_t smp;
    logic adc_valid;
    logic go;
    logic [15:0] hall;
    logic [11:0] aenc;
    logic [15:0] inc;
    logic signed [31:0] err;
    acfp_pkg::acfp_angle_t angles;
    acfp_pkg::acfp_current_t cur;
    logic [4:0] gnd;
    logic [15:0] aux;
    logic signed [31:0] gp;
    int miscompares;
    int tests_run;
    int cycles;
    acfp_path #(.ENC_BITS(12), .INC_BITS(16)) i_acfp_path (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_adc(adc),
        .i_adc_valid(adc_valid), .i_hall_angle(hall), .i_aenc_angle(aenc),
        .i_inc_count(inc), .i_loop_error(err), .o_angles(angles), .o_currents(cur),
        .o_neg_to_gnd(gnd), .o_aux_target(aux), .o_gain_product(gp)
    );
    acfp_sensor_model i_acfp_sensor_model (
        .i_clk(i_clk), .i_go(go), .i_smp(smp), .o_adc(adc), .o_valid(adc_valid)
    );
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // A hang is cut well beyond the fewer than two hundred cycles the scenarios need.
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("Checks made %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic send(input acfp_pkg::acfp_adc_raw_t s);
        @(posedge i_clk);
        smp <= s;
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        settle(8);
    endtask
    task automatic t_reset();
        rd_chk(acfp_pkg::REG_POLE_PAIRS, 32'h0000_0001);
        rd_chk(acfp_pkg::REG_CAL_FIRST, 32'h0100_0000);
        wr_reg(8'hFC, 32'hFFFF_FFFF);
        rd_chk(8'hFC, 32'h0000_0000);
    endtask
    task automatic t_angles();
        wr_reg(acfp_pkg::REG_POLE_PAIRS, 32'h0000_0003);
        wr_reg(acfp_pkg::REG_INPUT_CFG, 32'h0000_1000);
        aenc <= 12'h400;
        settle(3);
        check(angles, 32'hC000_4000);
        rd_chk(acfp_pkg::REG_ANGLES, 32'h4000_C000);
        wr_reg(acfp_pkg::REG_ANGLE_SHIFT, 32'h0000_5000);
        settle(3);
        check(angles, 32'h1000_4000);
        wr_reg(acfp_pkg::REG_ANGLE_SHIFT, 32'h0001_5000);
        settle(3);
        check(angles, 32'h7000_4000);
        @(posedge i_clk);
        aenc <= 12'hABC;
        settle(3);
        check({16'h0, angles.mechanical}, 32'h0000_ABC0);
        wr_reg(acfp_pkg::REG_ANGLE_SHIFT, 32'h0);
        wr_reg(acfp_pkg::REG_INPUT_CFG, 32'h0);
        hall <= 16'h9000;
        settle(3);
        check(angles, 32'h9000_3000);
        wr_reg(acfp_pkg::REG_INPUT_CFG, 32'h0000_3000);
        settle(3);
        check(angles, 32'h9000_3000);
        wr_reg(acfp_pkg::REG_INPUT_CFG, 32'h0000_2000);
        inc <= 16'h1234;
        wr_reg(acfp_pkg::REG_ENC_ZERO, 32'h0);
        inc <= 16'h1240;
        rd_chk(acfp_pkg::REG_ENC_ZERO, 32'h0000_000C);
    endtask
    task automatic t_samples();
        acfp_pkg::acfp_adc_raw_t s;
        s = {16'hFFFF, 16'hFFFF, 16'h0BCD, 16'h1357, 16'h2468, 16'h1234, 16'h5678, 16'h0ABC};
        wr_reg(acfp_pkg::REG_CAL_FIRST + 8'h04, 32'hFF00_0000);
        wr_reg(acfp_pkg::REG_INPUT_CFG, 32'h0000_0100);
        send(s);
        check({cur.first, cur.second}, 32'h7FFF_8001);
        check({16'h0, cur.derived}, 32'h0);
        check({16'h0, aux}, 32'h0000_1357);
        rd_chk(acfp_pkg::REG_POS_FIRST_INDEX, 32'h5678_1234);
        rd_chk(acfp_pkg::REG_POS_THIRD, 32'h0000_0ABC);
        rd_chk(acfp_pkg::REG_SUPPLY, 32'h0000_0BCD);
        rd_chk(acfp_pkg::REG_AUX, 32'h2468_1357);
        rd_chk(acfp_pkg::REG_CUR_MEAS, 32'h8001_7FFF);
        wr_reg(acfp_pkg::REG_CAL_LAST, 32'hFF00_0000);
        rd_chk(acfp_pkg::REG_POS_THIRD, 32'h0000_F544);
        for (int k = 0; k < 8; k++) begin
            wr_reg(acfp_pkg::REG_RAW_SEL, 32'(k));
            rd_chk(acfp_pkg::REG_RAW_VIEW, {16'h0, s[127-16*k -: 16]});
        end
        wr_reg(acfp_pkg::REG_CAL_FIRST + 8'h04, 32'h0100_0000);
        s.cur_second = 16'h0100;
        send(s);
        check({16'h0, cur.derived}, 32'h0000_8001);
        wr_reg(acfp_pkg::REG_CAL_FIRST, 32'h0100_8000);
        s.cur_first = 16'h8123;
        send(s);
        check({cur.first, cur.second}, 32'h0123_0100);
        check({16'h0, cur.derived}, 32'h0000_FDDD);
        rd_chk(acfp_pkg::REG_CUR_DERIVED, 32'h0000_FDDD);
    endtask
    task automatic t_gnd();
        wr_reg(acfp_pkg::REG_INPUT_CFG, 32'h0000_0015);
        settle(3);
        check({27'h0, gnd}, 32'h0000_0015);
    endtask
    task automatic t_gain();
        wr_reg(acfp_pkg::REG_GAIN, 32'h0000_FF80);
        err <= 32'sh0000_0100;
        settle(3);
        check(gp, 32'hFFFF_FF80);
        wr_reg(acfp_pkg::REG_GAIN, 32'h0001_0800);
        err <= 32'sh0000_1000;
        settle(3);
        check(gp, 32'h0000_0800);
        wr_reg(acfp_pkg::REG_GAIN, 32'h0000_7FFF);
        err <= 32'sh8000_0001;
        settle(3);
        check(gp, 32'h8000_0001);
        @(posedge i_clk);
        err <= 32'sh7FFF_FFFF;
        settle(3);
        check(gp, 32'h7FFF_FFFF);
        rd_chk(acfp_pkg::REG_GAIN_OUT, 32'h7FFF_FFFF);
    endtask
    initial begin
        cycles = 0;
        miscompares = 0;
        tests_run = 0;
        i_sys_rst = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        go = 1'b0;
        smp = '0;
        hall = 16'h0;
        aenc = 12'h0;
        inc = 16'h0;
        err = 32'sh0;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_reset();
        t_angles();
        t_samples();
        t_gnd();
        t_gain();
        summarize();
    end
endmodule
`default_nettype wire
